// ===== core/iqw_loader.sv
// I/Q waveform download parser, store, pairing and playback
`timescale 1ns/1ps
module iqw_loader
  import iqw_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Command, decoded upstream from the text part of the line
  input  wire logic                 cmd_valid,
  input  wire logic [1:0]           cmd_op,
  input  wire logic [1:0]           cmd_target,
  input  wire logic [NAME_W-1:0]    cmd_name,
  // Block bytes from the host
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_byte,
  // Bytes back to the host
  output logic                      tx_valid,
  output logic [7:0]                tx_byte,
  // Status
  output logic                      busy,
  output logic                      cmd_error,
  // Playback outputs
  output logic                      play_active,
  output logic [SAMPLE_W-1:0]       i_code,
  output logic [SAMPLE_W-1:0]       q_code,
  output logic                      marker1,
  output logic                      marker2
);
  typedef enum logic [3:0] {
    S_IDLE, S_HASH, S_NDIG, S_COUNT, S_DATA, S_TXHDR, S_TXDATA, S_COPY, S_PLAY
  } iqw_state_t;

  // Storage: [1] volatile, [0] nonvolatile, per stream; shared segment space
  logic [WORD_W-1:0]   vmem_i [MEM_POINTS];
  logic [WORD_W-1:0]   vmem_q [MEM_POINTS];
  logic [WORD_W-1:0]   nvmem_i [MEM_POINTS];
  logic [WORD_W-1:0]   nvmem_q [MEM_POINTS];

  // Directory per slot and per store: name, base, lengths of each half
  logic [NUM_SLOTS-1:0] dir_used   [2];
  logic [NAME_W-1:0]    dir_name   [2][NUM_SLOTS];
  logic [ADDR_W-1:0]    dir_base   [2][NUM_SLOTS];
  logic [ADDR_W:0]      dir_len_i  [2][NUM_SLOTS];
  logic [ADDR_W:0]      dir_len_q  [2][NUM_SLOTS];
  logic [ADDR_W:0]      dir_cap    [2][NUM_SLOTS];

  iqw_state_t          state_reg;
  logic [1:0]          op_reg;
  logic                nv_reg;
  logic                q_reg;
  logic [NAME_W-1:0]   name_reg;
  logic [SLOT_W-1:0]   slot_reg;
  logic [3:0]          ndig_reg;
  logic [CNT_W-1:0]    count_reg;
  logic [CNT_W-1:0]    left_reg;
  logic                half_reg;
  logic [7:0]          hi_reg;
  logic [ADDR_W:0]     ptr_reg;
  logic [ADDR_W:0]     end_reg;
  logic [ADDR_W-1:0]   base_reg;
  logic [ADDR_W:0]     cap_reg;
  logic [ADDR_W-1:0]   addr;
  logic [WORD_W-1:0]   rd_word;
  logic [3:0]          hdr_idx_reg;
  logic [CNT_W-1:0]    div_reg;

  // Slot lookup by name, in the selected store
  logic                hit;
  logic [SLOT_W-1:0]   hit_slot;
  logic                free_ok;
  logic [SLOT_W-1:0]   free_slot;
  logic [NUM_SLOTS-1:0] match_vec;

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_match
      assign match_vec[gs] = dir_used[cmd_target[1] ? 0 : 1][gs]
                             && (dir_name[cmd_target[1] ? 0 : 1][gs] == cmd_name);
    end
  endgenerate

  always_comb begin
    hit       = 1'b0;
    hit_slot  = '0;
    free_ok   = 1'b0;
    free_slot = '0;
    for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
      if (match_vec[k]) begin
        hit      = 1'b1;
        hit_slot = SLOT_W'(k);
      end
      if (!dir_used[cmd_target[1] ? 0 : 1][k]) begin
        free_ok   = 1'b1;
        free_slot = SLOT_W'(k);
      end
    end
  end

  // Allocator for first half of a new name
  logic                alloc_req;
  logic                alloc_ok;
  logic                alloc_fail;
  logic [SEG_IDX_W-1:0] alloc_base;
  logic [SEG_IDX_W:0]  alloc_nseg;
  logic [ADDR_W:0]     bytes_pts;
  logic [CNT_W-1:0]    count_next;
  logic [ADDR_W-1:0]   new_base;
  logic [ADDR_W:0]     new_cap;

  assign count_next = (count_reg * 10) + CNT_W'(rx_byte - CH_ZERO);
  assign bytes_pts  = (ADDR_W+1)'(count_next >> 1);
  // Only a name new to its store takes fresh segments; a rewrite keeps its space
  assign alloc_req  = (state_reg == S_COUNT) && rx_valid && (ndig_reg == 4'h1)
                      && !dir_used[nv_reg ? 0 : 1][slot_reg] && (count_next != '0);
  assign new_base   = ADDR_W'(alloc_base) << SEG_SHIFT;
  assign new_cap    = (ADDR_W+1)'(alloc_nseg) << SEG_SHIFT;

  iqw_seg_alloc u_alloc (
    .mclk     (mclk),
    .rst      (rst),
    .req      (alloc_req),
    .points   (bytes_pts),
    .ok       (alloc_ok),
    .fail     (alloc_fail),
    .base_seg (alloc_base),
    .nseg     (alloc_nseg)
  );

  // Digit emitter for the returned header
  logic [3:0]          tx_ndig;
  logic [CNT_W-1:0]    tx_count;
  logic [CNT_W-1:0]    pow10;
  assign tx_count = CNT_W'(end_reg) << 1;
  always_comb begin
    tx_ndig = 4'h1;
    pow10   = CNT_W'(1);
    for (int d = 1; d < CNT_DIG_MAX; d++) begin
      if (tx_count >= pow10 * 10) begin
        tx_ndig = 4'(d + 1);
        pow10   = pow10 * 10;
      end
    end
  end

  // Sequencing and store
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg   <= S_IDLE;
      op_reg      <= 2'h0;
      nv_reg      <= 1'b0;
      q_reg       <= 1'b0;
      name_reg    <= '0;
      slot_reg    <= '0;
      ndig_reg    <= 4'h0;
      count_reg   <= '0;
      left_reg    <= '0;
      half_reg    <= 1'b0;
      hi_reg      <= 8'h00;
      ptr_reg     <= '0;
      end_reg     <= '0;
      base_reg    <= '0;
      cap_reg     <= '0;
      hdr_idx_reg <= 4'h0;
      div_reg     <= '0;
      busy        <= 1'b0;
      cmd_error   <= 1'b0;
      tx_valid    <= 1'b0;
      tx_byte     <= 8'h00;
      dir_used[1] <= '0;
    end else begin
      tx_valid  <= 1'b0;
      cmd_error <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          busy <= 1'b0;
          if (cmd_valid && !busy) begin
            op_reg   <= cmd_op;
            nv_reg   <= cmd_target[1];
            q_reg    <= cmd_target[0];
            name_reg <= cmd_name;
            busy     <= 1'b1;
            if (cmd_op == 2'(IQW_CMD_DOWNLOAD)) begin
              if (!hit && !free_ok) begin
                cmd_error <= 1'b1;
                busy      <= 1'b0;
              end else begin
                slot_reg  <= hit ? hit_slot : free_slot;
                state_reg <= S_HASH;
              end
            end else if (!hit) begin
              cmd_error <= 1'b1;
              busy      <= 1'b0;
            end else begin
              slot_reg <= hit_slot;
              base_reg <= dir_base[cmd_target[1] ? 0 : 1][hit_slot];
              ptr_reg  <= '0;
              if (cmd_op == 2'(IQW_CMD_QUERY)) begin
                end_reg     <= cmd_target[0]
                               ? dir_len_q[cmd_target[1] ? 0 : 1][hit_slot]
                               : dir_len_i[cmd_target[1] ? 0 : 1][hit_slot];
                hdr_idx_reg <= 4'h0;
                state_reg   <= S_TXHDR;
              end else if (cmd_op == 2'(IQW_CMD_COPY)) begin
                end_reg   <= dir_cap[0][hit_slot];
                state_reg <= S_COPY;
              end else if (!cmd_target[1]) begin
                // Play only from the volatile store
                end_reg <= (dir_len_i[1][hit_slot] > dir_len_q[1][hit_slot])
                           ? dir_len_i[1][hit_slot] : dir_len_q[1][hit_slot];
                state_reg <= S_PLAY;
              end else begin
                cmd_error <= 1'b1;
                busy      <= 1'b0;
              end
            end
          end
        end
        S_HASH: begin
          if (rx_valid) begin
            state_reg <= (rx_byte == CH_HASH) ? S_NDIG : S_IDLE;
            cmd_error <= (rx_byte != CH_HASH);
          end
        end
        S_NDIG: begin
          if (rx_valid) begin
            ndig_reg  <= 4'(rx_byte - CH_ZERO);
            count_reg <= '0;
            hdr_idx_reg <= 4'h0;
            if ((rx_byte > CH_ZERO) && (rx_byte <= CH_ZERO + 8'(CNT_DIG_MAX))) begin
              state_reg <= S_COUNT;
            end else begin
              cmd_error <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
        end
        S_COUNT: begin
          if (rx_valid) begin
            ndig_reg  <= ndig_reg - 4'h1;
            count_reg <= count_next;
            if (ndig_reg == 4'h1) begin
              left_reg  <= count_next;
              half_reg  <= 1'b0;
              ptr_reg   <= '0;
              // A new name is overwritten by the allocator answer next cycle
              base_reg  <= dir_base[nv_reg ? 0 : 1][slot_reg];
              cap_reg   <= dir_cap[nv_reg ? 0 : 1][slot_reg];
              state_reg <= (count_next == '0) ? S_IDLE : S_DATA;
            end
          end
        end
        S_DATA: begin
          if (alloc_ok) begin
            base_reg <= new_base;
            cap_reg  <= new_cap;
          end
          if (alloc_fail) begin
            // Store full: rest of the block falls on an idle parser
            cmd_error <= 1'b1;
            state_reg <= S_IDLE;
          end else if (rx_valid) begin
            left_reg <= left_reg - CNT_W'(1);
            half_reg <= ~half_reg;
            if (!half_reg) begin
              hi_reg <= rx_byte;
            end else if (ptr_reg < cap_reg) begin
              // Rewrite longer than its first allocation is cut at the old size
              ptr_reg <= ptr_reg + (ADDR_W+1)'(1);
            end
            if (left_reg == CNT_W'(1)) begin
              // Close directory entry; a new name gets a zero-length other half
              dir_used[nv_reg ? 0 : 1][slot_reg] <= 1'b1;
              dir_name[nv_reg ? 0 : 1][slot_reg] <= name_reg;
              dir_base[nv_reg ? 0 : 1][slot_reg] <= alloc_ok ? new_base : base_reg;
              dir_cap[nv_reg ? 0 : 1][slot_reg]  <= alloc_ok ? new_cap : cap_reg;
              if (q_reg) begin
                dir_len_q[nv_reg ? 0 : 1][slot_reg] <= ptr_reg + (ADDR_W+1)'(half_reg);
              end else begin
                dir_len_i[nv_reg ? 0 : 1][slot_reg] <= ptr_reg + (ADDR_W+1)'(half_reg);
              end
              if (!dir_used[nv_reg ? 0 : 1][slot_reg]) begin
                if (q_reg) begin
                  dir_len_i[nv_reg ? 0 : 1][slot_reg] <= '0;
                end else begin
                  dir_len_q[nv_reg ? 0 : 1][slot_reg] <= '0;
                end
              end
              state_reg <= S_IDLE;
            end
          end
        end
        S_TXHDR: begin
          tx_valid    <= 1'b1;
          hdr_idx_reg <= hdr_idx_reg + 4'h1;
          if (hdr_idx_reg == 4'h0) begin
            tx_byte <= CH_HASH;
          end else if (hdr_idx_reg == 4'h1) begin
            tx_byte <= CH_ZERO + 8'(tx_ndig);
            div_reg <= pow10;
          end else begin
            tx_byte <= CH_ZERO + 8'((tx_count / div_reg) % 10);
            div_reg <= div_reg / 10;
            if (div_reg == CNT_W'(1)) begin
              half_reg  <= 1'b0;
              state_reg <= (end_reg == '0) ? S_IDLE : S_TXDATA;
            end
          end
        end
        S_TXDATA: begin
          tx_valid <= 1'b1;
          half_reg <= ~half_reg;
          if (!half_reg) begin
            tx_byte <= rd_word[15:8];
          end else begin
            tx_byte <= rd_word[7:0];
            ptr_reg <= ptr_reg + (ADDR_W+1)'(1);
            if (ptr_reg + (ADDR_W+1)'(1) == end_reg) begin
              state_reg <= S_IDLE;
            end
          end
        end
        S_COPY: begin
          ptr_reg <= ptr_reg + (ADDR_W+1)'(1);
          if (ptr_reg + (ADDR_W+1)'(1) == end_reg) begin
            dir_used[1][slot_reg]  <= 1'b1;
            dir_name[1][slot_reg]  <= name_reg;
            dir_base[1][slot_reg]  <= base_reg;
            dir_len_i[1][slot_reg] <= dir_len_i[0][slot_reg];
            dir_len_q[1][slot_reg] <= dir_len_q[0][slot_reg];
            dir_cap[1][slot_reg]   <= dir_cap[0][slot_reg];
            state_reg <= S_IDLE;
          end
        end
        S_PLAY: begin
          ptr_reg <= ptr_reg + (ADDR_W+1)'(1);
          if (ptr_reg + (ADDR_W+1)'(1) >= end_reg) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Memory ports: write during download and copy, read for query and play
  assign addr    = base_reg + ptr_reg[ADDR_W-1:0];
  assign rd_word = nv_reg ? (q_reg ? nvmem_q[addr] : nvmem_i[addr])
                          : (q_reg ? vmem_q[addr] : vmem_i[addr]);

  always_ff @(posedge mclk) begin
    if (state_reg == S_DATA && rx_valid && half_reg && ptr_reg < cap_reg) begin
      case ({nv_reg, q_reg})
        2'b00:   vmem_i[addr]  <= {hi_reg, rx_byte};
        2'b01:   vmem_q[addr]  <= {hi_reg, rx_byte};
        2'b10:   nvmem_i[addr] <= {hi_reg, rx_byte};
        default: nvmem_q[addr] <= {hi_reg, rx_byte};
      endcase
    end
    if (state_reg == S_COPY) begin
      vmem_i[addr] <= nvmem_i[addr];
      vmem_q[addr] <= nvmem_q[addr];
    end
  end

  // Playback outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      play_active <= 1'b0;
      i_code      <= ZERO_CODE;
      q_code      <= ZERO_CODE;
      marker1     <= 1'b0;
      marker2     <= 1'b0;
    end else if (state_reg == S_PLAY) begin
      play_active <= 1'b1;
      if (ptr_reg < dir_len_i[1][slot_reg]) begin
        i_code  <= vmem_i[addr][SAMPLE_W-1:0];
        marker1 <= vmem_i[addr][MARK1_BIT];
        marker2 <= vmem_i[addr][MARK2_BIT];
      end else begin
        i_code  <= ZERO_CODE;
        marker1 <= 1'b0;
        marker2 <= 1'b0;
      end
      // Quadrature upper bits are reserved; playback never looks at them
      q_code <= (ptr_reg < dir_len_q[1][slot_reg])
                ? vmem_q[addr][SAMPLE_W-1:0] : ZERO_CODE;
    end else begin
      play_active <= 1'b0;
      i_code      <= ZERO_CODE;
      q_code      <= ZERO_CODE;
      marker1     <= 1'b0;
      marker2     <= 1'b0;
    end
  end
endmodule

// ===== inc/iqw_pkg.sv
// Shared constants and types for the I/Q waveform store loader
package iqw_pkg;
  localparam int unsigned SAMPLE_W      = 14;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned MARK1_BIT     = 15;
  localparam int unsigned MARK2_BIT     = 14;
  localparam logic [13:0] ZERO_CODE     = 14'h2000;
  localparam int unsigned SEG_POINTS    = 4096;
  localparam int unsigned SEG_SHIFT     = 12;
  localparam int unsigned MEM_POINTS    = 1048576;
  localparam int unsigned ADDR_W        = 20;
  localparam int unsigned SEG_IDX_W     = 8;
  localparam int unsigned SLOT_W        = 3;
  localparam int unsigned NUM_SLOTS     = 8;
  localparam int unsigned NAME_W        = 8;
  localparam int unsigned CNT_DIG_MAX   = 9;
  localparam logic [7:0]  CH_HASH       = 8'h23;
  localparam logic [7:0]  CH_ZERO       = 8'h30;
  localparam int unsigned CNT_W         = 32;

  // Destination selected by file name prefix
  typedef enum logic [1:0] {
    volatile_inphase_target,
    volatile_quadrature_target,
    nonvolatile_inphase_target,
    nonvolatile_quadrature_target
  } iqw_target_t;

  typedef enum logic [1:0] {
    IQW_CMD_DOWNLOAD,
    IQW_CMD_QUERY,
    IQW_CMD_COPY,
    IQW_CMD_PLAY
  } iqw_cmd_t;
endpackage

// ===== core/iqw_seg_alloc.sv
// Segment allocator: rounds a point count up to whole segments
`timescale 1ns/1ps
module iqw_seg_alloc
  import iqw_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Request
  input  wire logic                 req,
  input  wire logic [ADDR_W:0]      points,
  // Answer
  output logic                      ok,
  output logic                      fail,
  output logic [SEG_IDX_W-1:0]      base_seg,
  output logic [SEG_IDX_W:0]        nseg
);
  logic [SEG_IDX_W:0] next_free_reg;
  logic [SEG_IDX_W:0] need;
  logic [SEG_IDX_W+1:0] total;

  // Zero points still take one segment
  always_comb begin
    need = (SEG_IDX_W+1)'((ADDR_W+1)'(points + (ADDR_W+1)'(SEG_POINTS - 1)) >> SEG_SHIFT);
    if (need == '0) begin
      need = (SEG_IDX_W+1)'(1);
    end
    total = {1'b0, next_free_reg} + {1'b0, need};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      next_free_reg <= '0;
      ok            <= 1'b0;
      fail          <= 1'b0;
      base_seg      <= '0;
      nseg          <= '0;
    end else begin
      ok   <= 1'b0;
      fail <= 1'b0;
      if (req) begin
        // Bump allocation only; space is freed only by reset
        if (total > (SEG_IDX_W+2)'(MEM_POINTS >> SEG_SHIFT)) begin
          fail <= 1'b1;
        end else begin
          ok            <= 1'b1;
          base_seg      <= next_free_reg[SEG_IDX_W-1:0];
          nseg          <= need;
          next_free_reg <= total[SEG_IDX_W:0];
        end
      end
    end
  end
endmodule

// ===== sim/iqw_loader_properties.sv
// Concurrent checks on the loader's ports
`timescale 1ns/1ps
module iqw_loader_properties
  import iqw_pkg::*;
(
  // Clock and reset
  input logic                mclk,
  input logic                rst,
  // Command and block bytes
  input logic                cmd_valid,
  input logic [1:0]          cmd_op,
  input logic [1:0]          cmd_target,
  input logic [NAME_W-1:0]   cmd_name,
  input logic                rx_valid,
  input logic [7:0]          rx_byte,
  input logic                tx_valid,
  input logic [7:0]          tx_byte,
  // Status and playback
  input logic                busy,
  input logic                cmd_error,
  input logic                play_active,
  input logic [SAMPLE_W-1:0] i_code,
  input logic [SAMPLE_W-1:0] q_code,
  input logic                marker1,
  input logic                marker2
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_take(logic [1:0] op);
    cmd_valid && !busy && cmd_op == op;
  endsequence
  sequence s_first(logic good);
    s_take(2'h0) ##1 (rx_valid && ((rx_byte == CH_HASH) == good));
  endsequence

  property p_cmd_busy;
    s_take(2'h0) |=> busy;
  endproperty
  property p_bad_hash;
    s_first(1'b0) |=> cmd_error;
  endproperty
  property p_hash_ok;
    s_first(1'b1) |=> !cmd_error;
  endproperty
  property p_err_idle;
    cmd_error |-> ##[0:1] !busy ##1 !cmd_error;
  endproperty
  property p_reset_codes;
    $fell(rst) |-> i_code == ZERO_CODE && q_code == ZERO_CODE && !marker1 && !marker2
      && !play_active;
  endproperty
  property p_nv_play;
    s_take(2'h3) ##0 cmd_target[1] |=> !play_active [*4];
  endproperty
  property p_vol_play;
    s_take(2'h3) ##0 !cmd_target[1] |-> ##[1:3] play_active;
  endproperty
  property p_query_hash;
    s_take(2'h1) |-> ##[1:4] (tx_valid && tx_byte == CH_HASH);
  endproperty

  a_cmd_busy: assert property (p_cmd_busy)
    else $error("download command did not raise busy");
  a_bad_hash: assert property (p_bad_hash)
    else $error("missing hash not flagged");
  a_hash_ok: assert property (p_hash_ok)
    else $error("good hash flagged as error");
  a_err_idle: assert property (p_err_idle)
    else $error("error not followed by idle");
  a_reset_codes: assert property (p_reset_codes)
    else $error("outputs not at zero level after reset");
  a_nv_play: assert property (p_nv_play)
    else $error("nonvolatile waveform played directly");
  a_vol_play: assert property (p_vol_play)
    else $error("volatile play did not start");
  a_query_hash: assert property (p_query_hash)
    else $error("query answer does not open with hash");
endmodule

// ===== sim/iqw_host_model.sv
// Host model: drives commands and framed blocks at the falling edge
`timescale 1ns/1ps
module iqw_host_model
  import iqw_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Command
  output logic             cmd_valid,
  output logic [1:0]       cmd_op,
  output logic [1:0]       cmd_target,
  output logic [NAME_W-1:0] cmd_name,
  // Block bytes
  output logic             rx_valid,
  output logic [7:0]       rx_byte
);
  initial begin
    cmd_valid  = 1'b0;
    cmd_op     = 2'h0;
    cmd_target = 2'h0;
    cmd_name   = 8'h00;
    rx_valid   = 1'b0;
    rx_byte    = 8'h00;
  end

  // Hash, digit count, decimal byte count, then words high byte first
  function automatic void frame(input logic [15:0] w[$], output logic [7:0] b[$]);
    string cnt;
    cnt = $sformatf("%0d", 2 * w.size());
    b = {CH_HASH, CH_ZERO + 8'(cnt.len())};
    for (int k = 0; k < cnt.len(); k++) b.push_back(8'(cnt[k]));
    foreach (w[k]) b = {b, w[k][15:8], w[k][7:0]};
  endfunction

  // Released name line shows the inverse so a stale name cannot pass
  task automatic command(input logic [1:0] op, input logic [1:0] tgt, input logic [7:0] nm);
    @(negedge mclk);
    cmd_valid  = 1'b1;
    cmd_op     = op;
    cmd_target = tgt;
    cmd_name   = nm;
    @(negedge mclk);
    cmd_valid  = 1'b0;
    cmd_name   = ~nm;
  endtask

  task automatic send_byte(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_byte  = b;
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_byte  = ~b;
  endtask

  // Caller keeps playback stopped and data in range
  task automatic download(input logic [1:0] tgt, input logic [7:0] nm, input logic [15:0] w[$]);
    logic [7:0] b[$];
    frame(w, b);
    command(2'h0, tgt, nm);
    rx_valid = 1'b1;
    foreach (b[k]) begin
      rx_byte = b[k];
      @(negedge mclk);
    end
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
  endtask
endmodule

// ===== sim/iqw_loader_tb.sv
// Self-checking bench for the I/Q waveform store loader
`timescale 1ns/1ps
bind iqw_loader iqw_loader_properties chk_u (
  .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_target(cmd_target),
  .cmd_name(cmd_name), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
  .tx_byte(tx_byte), .busy(busy), .cmd_error(cmd_error), .play_active(play_active),
  .i_code(i_code), .q_code(q_code), .marker1(marker1), .marker2(marker2)
);
module iqw_loader_tb import iqw_pkg::*; ;
  typedef struct {
    logic [1:0]  tgt;
    logic [7:0]  nm;
    logic [15:0] w0;
    logic [15:0] w1;
  } iqw_row_t;
  logic                mclk, rst, cmd_valid, rx_valid, tx_valid, busy, cmd_error;
  logic                play_active, marker1, marker2;
  logic [1:0]          cmd_op, cmd_target;
  logic [7:0]          cmd_name, rx_byte, tx_byte;
  logic [SAMPLE_W-1:0] i_code, q_code;
  logic [7:0]          txq[$];
  logic [29:0]         pq[$], ep[$];
  logic [15:0]         iw[$], qw[$];
  int                  n_fail, samples_checked, cycles, n_err;
  iqw_row_t            rows[4];

  iqw_loader dut_u (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_target(cmd_target),
    .cmd_name(cmd_name), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .busy(busy), .cmd_error(cmd_error), .play_active(play_active),
    .i_code(i_code), .q_code(q_code), .marker1(marker1), .marker2(marker2)
  );
  iqw_host_model host_u (
    .mclk(mclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_target(cmd_target),
    .cmd_name(cmd_name), .rx_valid(rx_valid), .rx_byte(rx_byte)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Sample registered outputs at the edge, before it updates them
  always @(posedge mclk) begin
    cycles++;
    if (tx_valid === 1'b1) txq.push_back(tx_byte);
    if (play_active === 1'b1) pq.push_back({marker1, marker2, i_code, q_code});
    if (cmd_error === 1'b1) n_err++;
    if (cycles == 40000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 6000 && (busy !== 1'b0 || play_active !== 1'b0); k++) @(negedge mclk);
    check("idle", 2'b00, {busy, play_active});
  endtask

  task automatic dl(input logic [1:0] tgt, input logic [7:0] nm, input logic [15:0] w[$]);
    host_u.download(tgt, nm, w);
    wait_idle();
  endtask

  task automatic query_chk(input logic [1:0] tgt, input logic [7:0] nm, input logic [15:0] w[$]);
    logic [7:0] e[$];
    host_u.frame(w, e);
    txq = {};
    host_u.command(2'h1, tgt, nm);
    wait_idle();
    repeat (2) @(negedge mclk);
    check("query length", e.size(), txq.size());
    foreach (e[k]) check("query byte", e[k], txq[k]);
  endtask

  task automatic play_chk(input logic [1:0] tgt, input logic [7:0] nm, input logic [29:0] e[$]);
    pq = {};
    host_u.command(2'h3, tgt, nm);
    repeat (3) @(negedge mclk);
    wait_idle();
    check("play length", e.size(), pq.size());
    foreach (e[k]) check("play point", e[k], pq[k]);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    check("reset outputs", {ZERO_CODE, ZERO_CODE, 4'h0},
          {i_code, q_code, marker1, marker2, busy, play_active});
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    n_err = 0;
    rows = '{'{2'h0, 8'h11, 16'hc000, 16'h3fff}, '{2'h1, 8'h11, 16'h0000, 16'h2000},
             '{2'h2, 8'h12, 16'h8001, 16'h1234}, '{2'h3, 8'h12, 16'h0abc, 16'h3ffe}};
    do_reset();
    foreach (rows[r]) dl(rows[r].tgt, rows[r].nm, '{rows[r].w0, rows[r].w1});
    foreach (rows[r]) query_chk(rows[r].tgt, rows[r].nm, '{rows[r].w0, rows[r].w1});
    // Bad first byte of a block
    n_err = 0;
    host_u.command(2'h0, 2'h0, 8'h20);
    host_u.send_byte(8'h41);
    wait_idle();
    check("header error", 1, n_err);
    // Unequal halves with every marker pattern
    for (int k = 0; k < 20; k++) iw.push_back({2'(k), 14'(k * 800)});
    for (int k = 0; k < 16; k++) qw.push_back({2'b00, 14'(16383 - k * 1000)});
    dl(2'h0, 8'h21, iw);
    dl(2'h1, 8'h21, qw);
    for (int k = 0; k < 20; k++) ep.push_back({iw[k][15], iw[k][14], iw[k][13:0],
                                               (k < 16) ? qw[k][13:0] : ZERO_CODE});
    play_chk(2'h0, 8'h21, ep);
    // Quadrature half only
    dl(2'h1, 8'h22, qw);
    ep = {};
    for (int k = 0; k < 16; k++) ep.push_back({2'b00, ZERO_CODE, qw[k][13:0]});
    play_chk(2'h0, 8'h22, ep);
    // Just past one segment: needs a second segment to keep every point
    iw = {};
    ep = {};
    for (int k = 0; k < 4100; k++) begin
      iw.push_back({2'b00, 14'(k)});
      ep.push_back({2'b00, 14'(k), ZERO_CODE});
    end
    dl(2'h0, 8'h23, iw);
    play_chk(2'h0, 8'h23, ep);
    // Nonvolatile needs a copy before it plays
    ep = {};
    play_chk(2'h2, 8'h12, ep);
    host_u.command(2'h2, 2'h2, 8'h12);
    repeat (2) @(negedge mclk);
    wait_idle();
    query_chk(2'h0, 8'h12, '{rows[2].w0, rows[2].w1});
    do_reset();
    query_chk(2'h2, 8'h12, '{rows[2].w0, rows[2].w1});
    // Volatile copy is gone after reset
    n_err = 0;
    host_u.command(2'h1, 2'h0, 8'h12);
    repeat (2) @(negedge mclk);
    wait_idle();
    check("volatile lost", 1, n_err);
    close_out();
  end
endmodule
